// [core/acsq_top.sv]
// The address map and the APB slave port were chosen for this implementation.
module acsq_top
  import acsq_pkg::*;
(
  // APB
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Converter
  input  wire logic        convert_pin,
  input  wire logic [11:0] adc_code,
  output logic      [3:0]  adc_mux,
  output logic             temp_high_current,
  // Handshake and alarms
  output logic             data_ready_n,
  output logic             global_alarm_n,
  output logic      [3:0]  gpio_alarm_n,
  // Reference control
  output logic             ref_source_select,
  output logic             ref_level_select
);

  function automatic logic hit(input logic [7:0] a, input logic [5:0] idx);
    return (a[1:0] == 2'b00) && (a[7:2] == idx);
  endfunction : hit

  ////////////////////////////////////////////////////////////////////////////
  logic              conv_meta_reg;
  logic              conv_sync_reg;
  logic              conv_prev_reg;
  logic              ext_trigger_enable_reg;
  logic              ref_src_reg;
  logic              ref_lvl_reg;
  logic [3:0]        gpio_en_reg;
  logic [3:0]        scan_first_channel_reg;
  logic [3:0]        scan_last_channel_reg;
  logic              conversion_kind_reg;
  acsq_state_e       state_reg;
  logic [3:0]        cur_ch_reg;
  logic [7:0]        cnt_reg;
  logic              temp_phase_reg;
  logic [11:0]       temp_first_reg;
  logic [11:0]       staging_register [NUM_CH];
  logic [11:0]       result_reg [NUM_CH];
  logic [11:0]       thr_reg [2*NUM_MON];
  logic [NUM_CH-1:0] pend_reg;
  logic              notify_reg;
  logic              notify_auto_reg;
  logic              data_ready_flag_reg;
  logic [5:0]        pulse_reg;
  logic [3:0]        range_alarm_flag_reg;
  logic [31:0]       prdata_reg;
  logic              pready_reg;
  logic              pslverr_reg;
  logic              data_ready_n_reg;
  logic              global_alarm_n_reg;
  logic [3:0]        gpio_alarm_n_reg;
  logic              temp_high_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode
  wire        setup      = psel & ~penable;
  wire        done       = psel & penable & pready_reg;
  wire        wr         = done & pwrite;
  wire [5:0]  word       = paddr[7:2];
  wire        mapped     = (paddr[1:0] == 2'b00) && (word <= IDX_LAST);
  wire        rd_result  = done & ~pwrite & mapped & (word < IDX_ALARM);
  wire        ctrl_wr    = wr & hit(paddr, IDX_CTRL);
  wire        status_wr  = wr & hit(paddr, IDX_STATUS);

  // R24 edge detect
  wire        ext_edge   = conv_sync_reg & ~conv_prev_reg;
  // R1 R2 trigger select
  wire        trigger    = ext_trigger_enable_reg ? ext_edge : ctrl_wr;
  wire [3:0]  first_next = ctrl_wr ? pwdata[CT_FIRST_LO +: 4] : scan_first_channel_reg;
  // R4 R5 mode decode
  wire        auto_mode  = ~ext_trigger_enable_reg & conversion_kind_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer decode
  wire        conv_end   = (state_reg == ACSQ_CONV) && (cnt_reg == 8'(CONV_CYCLES - 1));
  wire        temp_step1 = (cur_ch_reg == TEMP_CH) && !temp_phase_reg;
  wire        ch_done    = conv_end && !temp_step1;
  // R3 end of group, nine channels at most
  wire        last_hit   = (cur_ch_reg == scan_last_channel_reg) || (cur_ch_reg == TEMP_CH);
  wire        scan_end   = ch_done && last_hit;
  // R22 difference of the two drive currents
  wire [11:0] temp_diff  = (temp_first_reg >= adc_code) ? temp_first_reg - adc_code : 12'h000;
  wire [11:0] result_val = (cur_ch_reg == TEMP_CH) ? temp_diff : adc_code;

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conv_meta_reg <= 1'b0;
      conv_sync_reg <= 1'b0;
      conv_prev_reg <= 1'b0;
    end else begin
      conv_meta_reg <= convert_pin;
      conv_sync_reg <= conv_meta_reg;
      conv_prev_reg <= conv_sync_reg;
    end
  end

  // R20 R21 configuration, both reference bits reset to 0
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_trigger_enable_reg <= 1'b0;
      ref_src_reg            <= 1'b0;
      ref_lvl_reg            <= 1'b0;
      gpio_en_reg            <= 4'h0;
      scan_first_channel_reg <= 4'h0;
      scan_last_channel_reg  <= 4'h0;
      conversion_kind_reg    <= 1'b0;
    end else begin
      if (status_wr) begin
        ext_trigger_enable_reg <= pwdata[ST_EXT_TRIG];
        ref_src_reg            <= pwdata[ST_REF_SRC];
        ref_lvl_reg            <= pwdata[ST_REF_LVL];
        gpio_en_reg            <= pwdata[ST_GPIO_LO +: 4];
      end
      if (ctrl_wr) begin
        scan_first_channel_reg <= pwdata[CT_FIRST_LO +: 4];
        scan_last_channel_reg  <= pwdata[CT_LAST_LO +: 4];
        conversion_kind_reg    <= pwdata[CT_KIND];
      end
    end
  end

  genvar t;
  generate
    for (t = 0; t < 2 * NUM_MON; t++) begin : g_thr
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          thr_reg[t] <= (t % 2 == 0) ? THR_HI_RESET : THR_LO_RESET;
        end else if (wr && hit(paddr, IDX_THR0 + 6'(t))) begin
          thr_reg[t] <= pwdata[DATA_W-1:0];
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Scan sequencer; a trigger always restarts from the first channel
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg      <= ACSQ_IDLE;
      cur_ch_reg     <= 4'h0;
      cnt_reg        <= 8'h00;
      temp_phase_reg <= 1'b0;
      temp_first_reg <= 12'h000;
      temp_high_reg  <= 1'b0;
    end else if (trigger) begin
      // R7 new trigger restarts
      state_reg      <= ACSQ_CONV;
      cur_ch_reg     <= first_next;
      cnt_reg        <= 8'h00;
      temp_phase_reg <= 1'b0;
      temp_high_reg  <= (first_next == TEMP_CH);
    end else if (state_reg == ACSQ_CONV) begin
      // R25 fixed conversion length
      cnt_reg <= conv_end ? 8'h00 : cnt_reg + 8'h01;
      if (conv_end && temp_step1) begin
        // R22 switch to low current
        temp_first_reg <= adc_code;
        temp_phase_reg <= 1'b1;
        temp_high_reg  <= 1'b0;
      end else if (scan_end) begin
        temp_phase_reg <= 1'b0;
        // R6 R7 loop only while auto mode holds
        if (auto_mode) begin
          cur_ch_reg    <= scan_first_channel_reg;
          temp_high_reg <= (scan_first_channel_reg == TEMP_CH);
        end else begin
          state_reg     <= ACSQ_IDLE;
          temp_high_reg <= 1'b0;
        end
      end else if (ch_done) begin
        cur_ch_reg    <= cur_ch_reg + 4'h1;
        temp_high_reg <= (cur_ch_reg + 4'h1 == TEMP_CH);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Two-stage result buffer
  logic [NUM_CH-1:0] busy;
  logic [NUM_CH-1:0] pend_next;
  genvar n;
  generate
    for (n = 0; n < NUM_CH; n++) begin : g_ch
      // R11 copy held off while this register is being read out
      assign busy[n]      = psel & ~pwrite & hit(paddr, IDX_RESULT0 + 6'(n));
      assign pend_next[n] = scan_end | (pend_reg[n] & busy[n]);
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          staging_register[n] <= 12'h000;
          result_reg[n]       <= 12'h000;
        end else begin
          // R9 R12 staging by channel address
          if (ch_done && cur_ch_reg == 4'(n)) begin
            staging_register[n] <= result_val;
          end
          // R10 copy after the last channel
          if (pend_reg[n] && !busy[n]) begin
            result_reg[n] <= staging_register[n];
          end
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Ready handshake
  wire       update_done = notify_reg && (pend_reg == '0);
  wire       flag_next   = (update_done && !notify_auto_reg) ? 1'b1 :
                           (rd_result || trigger || auto_mode) ? 1'b0 : data_ready_flag_reg;
  wire [5:0] pulse_next  = (update_done && notify_auto_reg) ? 6'(PULSE_CYCLES) :
                           (pulse_reg != 6'h00) ? pulse_reg - 6'h01 : 6'h00;

  // Range check of the first four channels of the group
  wire [3:0]  mon_off   = cur_ch_reg - scan_first_channel_reg;
  wire        mon       = ch_done && (cur_ch_reg >= scan_first_channel_reg) && (mon_off < 4'(NUM_MON));
  wire [11:0] thr_hi    = thr_reg[{mon_off[1:0], 1'b0}];
  wire [11:0] thr_lo    = thr_reg[{mon_off[1:0], 1'b1}];
  wire        oor       = (result_val > thr_hi) || (result_val < thr_lo);
  wire [3:0]  alarm_set = (mon && oor) ? (4'h1 << mon_off[1:0]) : 4'h0;
  // R19 trigger clears alarms
  wire [3:0]  alarm_next = trigger ? 4'h0 : (range_alarm_flag_reg | alarm_set);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_reg             <= '0;
      notify_reg           <= 1'b0;
      notify_auto_reg      <= 1'b0;
      data_ready_flag_reg  <= 1'b0;
      pulse_reg            <= 6'h00;
      data_ready_n_reg     <= 1'b1;
      range_alarm_flag_reg <= 4'h0;
      global_alarm_n_reg   <= 1'b1;
      gpio_alarm_n_reg     <= 4'hf;
    end else begin
      pend_reg             <= pend_next;
      notify_reg           <= scan_end | (notify_reg & ~update_done);
      notify_auto_reg      <= scan_end ? auto_mode : notify_auto_reg;
      // R14 R15 direct flag, set wins over clear
      data_ready_flag_reg  <= flag_next;
      // R16 auto pulse
      pulse_reg            <= pulse_next;
      data_ready_n_reg     <= ~(flag_next | (pulse_next != 6'h00));
      // R17 per-channel and global alarms
      range_alarm_flag_reg <= alarm_next;
      global_alarm_n_reg   <= ~(|alarm_next);
      // R18 alarm on enabled pins
      gpio_alarm_n_reg     <= ~(alarm_next & gpio_en_reg);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read mux; captured in setup so access phase needs no wait
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (word < IDX_ALARM) begin
      rd_mux = {20'h00000, result_reg[word[3:0]]};
    end else if (word == IDX_ALARM) begin
      rd_mux = {28'h0000000, range_alarm_flag_reg};
    end else if (word == IDX_STATUS) begin
      rd_mux[ST_EXT_TRIG]       = ext_trigger_enable_reg;
      rd_mux[ST_REF_SRC]        = ref_src_reg;
      rd_mux[ST_REF_LVL]        = ref_lvl_reg;
      rd_mux[ST_READY_FLAG]     = data_ready_flag_reg;
      rd_mux[ST_BUSY]           = (state_reg == ACSQ_CONV);
      rd_mux[ST_GPIO_LO +: 4]   = gpio_en_reg;
    end else if (word == IDX_CTRL) begin
      rd_mux[CT_FIRST_LO +: 4]  = scan_first_channel_reg;
      rd_mux[CT_LAST_LO +: 4]   = scan_last_channel_reg;
      rd_mux[CT_KIND]           = conversion_kind_reg;
    end else if (word <= IDX_LAST) begin
      rd_mux = {20'h00000, thr_reg[3'(word - IDX_THR0)]};
    end
    if (!mapped) begin
      rd_mux = 32'h0000_0000;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg  <= 32'h0000_0000;
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
    end else begin
      prdata_reg  <= setup ? rd_mux : prdata_reg;
      pready_reg  <= setup;
      pslverr_reg <= setup & ~mapped;
    end
  end

  assign prdata            = prdata_reg;
  assign pready            = pready_reg;
  assign pslverr           = pslverr_reg;
  assign adc_mux           = cur_ch_reg;
  assign temp_high_current = temp_high_reg;
  assign data_ready_n      = data_ready_n_reg;
  assign global_alarm_n    = global_alarm_n_reg;
  assign gpio_alarm_n      = gpio_alarm_n_reg;
  assign ref_source_select = ref_src_reg;
  assign ref_level_select  = ref_lvl_reg;

endmodule : acsq_top

// [core/acsq_pkg.sv]
// Functional notes
// R1 - Rising convert pin starts scan when enabled
// R2 - Control register write starts scan otherwise
// R3 - Convert first to last channel, nine max
// R4 - Conversion kind picks single or continuous
// R5 - External triggering forces single pass
// R6 - Direct mode: one pass, then idle
// R7 - Auto repeats until retrigger or mode change
// R8 - Host keeps last channel not below first
// R9 - Each result lands in its staging register
// R10 - Last channel copies staging to results
// R11 - Result copy waits for ongoing read
// R12 - Channel n to result n, 8 temperature
// R13 - Host keeps bus quiet during conversion
// R14 - Direct mode completion sets flag, pin low
// R15 - Result read or restart clears flag
// R16 - Auto mode: 2us ready pulse, flag zero
// R17 - First four channels checked, global alarm
// R18 - Four pins show individual alarms
// R19 - New trigger clears alarms, releases pin
// R20 - Reference source bit, internal by default
// R21 - Reference level bit, 1.25V default
// R22 - Temperature: high then low current, difference
// R23 - Host includes temperature in auto group
// R24 - Convert pin synchronised, one request per edge
// R25 - Conversion length is a cycle count
package acsq_pkg;

  localparam int          CLK_PERIOD_NS   = 50;
  localparam int          CONV_TIME_NS    = 5000;
  localparam int          CONV_CYCLES     = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          PULSE_TIME_NS   = 2000;
  localparam int          PULSE_CYCLES    = PULSE_TIME_NS / CLK_PERIOD_NS;

  localparam int          NUM_CH          = 9;
  localparam logic [3:0]  TEMP_CH         = 4'h8;
  localparam int          NUM_MON         = 4;
  localparam int          DATA_W          = 12;

  // Word indices; byte address is four times the index
  localparam logic [5:0]  IDX_RESULT0     = 6'h00;
  localparam logic [5:0]  IDX_ALARM       = 6'h09;
  localparam logic [5:0]  IDX_STATUS      = 6'h0a;
  localparam logic [5:0]  IDX_CTRL        = 6'h0b;
  localparam logic [5:0]  IDX_THR0        = 6'h0c;
  localparam logic [5:0]  IDX_LAST        = 6'h13;

  // Status/configuration fields
  localparam int          ST_EXT_TRIG     = 0;
  localparam int          ST_REF_SRC      = 1;
  localparam int          ST_REF_LVL      = 2;
  localparam int          ST_READY_FLAG   = 3;
  localparam int          ST_BUSY         = 4;
  localparam int          ST_GPIO_LO      = 8;

  // ADC control fields
  localparam int          CT_FIRST_LO     = 0;
  localparam int          CT_LAST_LO      = 4;
  localparam int          CT_KIND         = 8;

  localparam logic [11:0] THR_HI_RESET    = 12'hfff;
  localparam logic [11:0] THR_LO_RESET    = 12'h000;

  typedef enum logic {
    ACSQ_IDLE,
    ACSQ_CONV
  } acsq_state_e;

endpackage : acsq_pkg

// [bench/acsq_adc_model.sv]
module acsq_adc_model (
  // Converter side
  input  wire logic [3:0]  adc_mux,
  input  wire logic        temp_high_current,
  // Bench seed value
  input  wire logic [7:0]  base,
  output logic      [11:0] adc_code
);
  timeunit 1ns;
  timeprecision 1ns;
  // two-current temperature codes
  // Drive step leaves the difference at 12'h800
  assign adc_code = (adc_mux != 4'h8) ? {adc_mux, base} :
                    temp_high_current ? {4'ha, base} : {4'h2, base};
endmodule : acsq_adc_model

// [bench/acsq_assertions.sv]
module acsq_checker (
  // Clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // APB
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Converter
  input wire logic        convert_pin,
  input wire logic [11:0] adc_code,
  input wire logic [3:0]  adc_mux,
  input wire logic        temp_high_current,
  // Handshake, alarms and reference
  input wire logic        data_ready_n,
  input wire logic        global_alarm_n,
  input wire logic [3:0]  gpio_alarm_n,
  input wire logic        ref_source_select,
  input wire logic        ref_level_select
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  mux_range_a: assert property (adc_mux <= 4'h8)
    else $error("channel index above eight");
  mux_hold_a: assert property ($changed(adc_mux) |=> $stable(adc_mux) [*8])
    else $error("channel switched inside a conversion");
  temp_mux_a: assert property (temp_high_current |-> adc_mux == 4'h8)
    else $error("high current outside temperature channel");
  temp_hold_a: assert property ($rose(temp_high_current) |=> temp_high_current [*8])
    else $error("high current step cut short");
  alarm_pin_a: assert property (!(&gpio_alarm_n) |-> !global_alarm_n)
    else $error("single alarm without global alarm");
  ref_src_a: assert property ($changed(ref_source_select) |-> $past(psel && penable && pwrite))
    else $error("reference source moved without a write");
  ref_lvl_a: assert property ($changed(ref_level_select) |-> $past(psel && penable && pwrite))
    else $error("reference level moved without a write");
  ready_clr_a: assert property (psel && penable && pready && !pwrite && paddr <= 8'h20
    && !data_ready_n |-> ##[1:2] data_ready_n)
    else $error("result read left ready pin low");
endmodule : acsq_checker
bind acsq_top acsq_checker u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .pready(pready), .pslverr(pslverr), .convert_pin(convert_pin), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .adc_code(adc_code), .adc_mux(adc_mux),
  .gpio_alarm_n(gpio_alarm_n), .temp_high_current(temp_high_current), .data_ready_n(data_ready_n),
  .global_alarm_n(global_alarm_n), .ref_source_select(ref_source_select),
  .ref_level_select(ref_level_select));

// [bench/adc_scan_sequencer_bench.sv]
module adc_scan_sequencer_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, convert_pin = 0;
  logic [7:0]  paddr = 8'h00, base = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic        pready, pslverr, temp_high_current, data_ready_n, global_alarm_n;
  logic        ref_source_select, ref_level_select;
  logic [3:0]  adc_mux, gpio_alarm_n;
  logic [11:0] adc_code;
  logic [32:0] exp_q[$];
  int          n_mismatch = 0, cmp_count = 0, seed = 77, k;
  always #25 pclk = ~pclk;
  acsq_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .convert_pin(convert_pin), .adc_code(adc_code), .adc_mux(adc_mux),
    .temp_high_current(temp_high_current), .data_ready_n(data_ready_n),
    .global_alarm_n(global_alarm_n), .gpio_alarm_n(gpio_alarm_n),
    .ref_source_select(ref_source_select), .ref_level_select(ref_level_select));
  acsq_adc_model u_adc (.adc_mux(adc_mux), .temp_high_current(temp_high_current), .base(base),
    .adc_code(adc_code));
  ////////////////////////////////////////////////////////////////
  task summarize;
    if (n_mismatch == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : summarize
  task chk(input string nm, input logic [32:0] e, input logic [32:0] g);
    cmp_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // Request held until pready is seen at a rising edge
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    n = 0;
    do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin chk("pready", 33'h1, 33'h0); summarize(); end
    psel <= 0; penable <= 0;
  endtask : apb
  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task rd(input logic [7:0] a, input logic [32:0] e);
    exp_q.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask : rd
  task wait_low;
    k = 0;
    while (data_ready_n !== 1'b0 && k < 3000) begin @(posedge pclk); k++; end
    if (k >= 3000) begin chk("ready wait", 33'h0, 33'h1); summarize(); end
  endtask : wait_low
  task new_base;
    @(posedge pclk);
    base <= 8'($random(seed));
  endtask : new_base
  // Oldest note against each completed read
  always @(posedge pclk)
    if (psel && penable && pready === 1'b1 && !pwrite) chk("read", exp_q.pop_front(), {pslverr, prdata});
  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    chk("ref", 33'h0, {ref_source_select, ref_level_select});
    chk("pins", 33'h3f, {data_ready_n, global_alarm_n, gpio_alarm_n});
    rd(8'h28, 33'h0);
    rd(8'h30, 33'hfff);
    wr(8'h24, 32'hf);
    rd(8'h24, 33'h0);
    rd(8'h50, 33'h100000000);
    rd(8'h01, 33'h100000000);
    new_base();
    wr(8'h2c, 32'h10);
    wait_low();
    rd(8'h28, 33'h8);
    rd(8'h00, {4'h0, base});
    rd(8'h04, {4'h1, base});
    repeat (3) @(posedge pclk);
    chk("ready pin", 33'h1, data_ready_n);
    new_base();
    wr(8'h2c, 32'h87);
    wait_low();
    rd(8'h1c, {4'h7, base});
    rd(8'h20, 33'h800);
    wr(8'h30, 32'h10);
    wr(8'h28, 32'h100);
    new_base();
    wr(8'h2c, 32'h22);
    wait_low();
    rd(8'h24, 33'h1);
    chk("alarm pins", 33'h0e, {global_alarm_n, gpio_alarm_n});
    wr(8'h30, 32'hfff);
    wr(8'h2c, 32'h22);
    repeat (2) @(posedge pclk);
    chk("alarm release", 33'h1, global_alarm_n);
    wait_low();
    rd(8'h24, 33'h0);
    rd(8'h08, {4'h2, base});
    wr(8'h28, 32'h107);
    @(posedge pclk);
    chk("ref set", 33'h3, {ref_source_select, ref_level_select});
    new_base();
    wr(8'h2c, 32'h133);
    repeat (30) @(posedge pclk);
    chk("no start", 33'h1, data_ready_n);
    convert_pin <= 1;
    repeat (4) @(posedge pclk);
    convert_pin <= 0;
    wait_low();
    rd(8'h0c, {4'h3, base});
    repeat (150) @(posedge pclk);
    rd(8'h28, 33'h107);
    wr(8'h28, 32'h0);
    new_base();
    wr(8'h2c, 32'h100);
    wait_low();
    k = 0;
    while (data_ready_n === 1'b0 && k < 100) begin @(posedge pclk); k++; end
    chk("pulse", 33'd40, 33'(k));
    rd(8'h28, 33'h10);
    wait_low();
    repeat (50) @(posedge pclk);
    rd(8'h00, {4'h0, base});
    wr(8'h2c, 32'h00);
    wait_low();
    repeat (60) @(posedge pclk);
    chk("level", 33'h0, data_ready_n);
    rd(8'h28, 33'h8);
    summarize();
  end
endmodule : adc_scan_sequencer_bench
